/* riu_pkg.sv */
// package of opcodes, widths and bit positions for the return instruction unit
package riu_pkg;
   localparam int unsigned RIU_IW     = 14;
   localparam int unsigned RIU_PCW    = 13;
   localparam int unsigned RIU_DW     = 8;
   localparam logic [13:0] RIU_OP_RETI   = 14'h0009;
   localparam logic [13:0] RIU_OP_RET    = 14'h0008;
   localparam logic [13:0] RIU_LIT_MASK  = 14'h3C00;
   localparam logic [13:0] RIU_LIT_MATCH = 14'h3400;
   localparam int unsigned RIU_IEN_BIT   = 7;   // global interrupt enable position in control reg
   localparam int unsigned RIU_LIT_LSB   = 0;
   localparam int unsigned RIU_CYCLES    = 2;

   typedef enum logic [1:0] {RIU_NONE, RIU_RETI, RIU_RETLIT, RIU_RET} riu_kind_e;
   typedef enum {RIU_EXEC, RIU_FLUSH} riu_state_e;
endpackage : riu_pkg

/* riu_decode.sv */
// combinational opcode classifier for the three return instructions
`timescale 1ns/10ps
module riu_decode
   import riu_pkg::*;
(
   input  wire logic [RIU_IW-1:0] i_instr,   // instruction word
   output riu_kind_e              o_kind     // decoded return kind
);
   always_comb begin
      if (i_instr == RIU_OP_RETI) begin
         o_kind = RIU_RETI;
      end else if (i_instr == RIU_OP_RET) begin
         o_kind = RIU_RET;
      end else if ((i_instr & RIU_LIT_MASK) == RIU_LIT_MATCH) begin
         o_kind = RIU_RETLIT;   // bits 9:8 ignored
      end else begin
         o_kind = RIU_NONE;
      end
   end
endmodule : riu_decode

/* riu_return_unit.sv */
// return instruction unit: decode and two-cycle execution of the return group
// Operation
// RQ1: interrupt-return opcode pops stack, program counter takes top of stack.
// RQ2: interrupt-return sets global interrupt enable, bit 7 of interrupt control.
// RQ3: interrupt-return is one word, two cycles, flags unchanged.
// RQ4: literal return loads the low eight instruction bits into working register.
// RQ5: literal return pops stack into program counter.
// RQ6: literal return is one word, two cycles, flags unchanged.
// RQ7: subroutine-return opcode pops stack, program counter takes top of stack.
// RQ8: subroutine return is one word, two cycles, flags unchanged.
// RQ9: second cycle flushes prefetch as no-op; plain returns keep interrupt enable.
`timescale 1ns/10ps
module riu_return_unit
   import riu_pkg::*;
(
   input  wire logic               i_clk,         // core clock
   input  wire logic               i_rst,         // async reset, high
   input  wire logic               i_cyc_en,      // instruction cycle enable
   input  wire logic [RIU_IW-1:0]  i_instr,       // instruction being executed
   input  wire logic [RIU_PCW-1:0] i_top_of_stack,// stack top value
   output logic                    o_pop,         // stack pop pulse
   output logic                    o_pc_load,     // program counter load pulse
   output logic [RIU_PCW-1:0]      o_pc_value,    // new program counter
   output logic                    o_w_load,      // working register load pulse
   output logic [RIU_DW-1:0]       o_w_value,     // working register value
   output logic                    o_global_interrupt_enable_set, // set interrupt enable pulse
   output logic [2:0]              o_global_interrupt_enable_bit, // bit index in control reg
   output logic                    o_flush,       // execute prefetched as no-op
   output logic                    o_busy,        // return in progress
   output logic                    o_flags_we     // status flag write, always 0
);
   typedef struct packed {
      riu_state_e           st;
      logic                 pop;
      logic                 pc_load;
      logic [RIU_PCW-1:0]   pc_value;
      logic                 w_load;
      logic [RIU_DW-1:0]    w_value;
      logic                 ien_set;
      logic                 flush;
   } riu_state_s;

   riu_state_s r_reg;
   riu_state_s r_next;
   riu_kind_e  kind;

   riu_decode u_dec (
      .i_instr (i_instr),
      .o_kind  (kind)
   );

   always_comb begin
      r_next         = r_reg;
      r_next.pop     = 1'b0;
      r_next.pc_load = 1'b0;
      r_next.w_load  = 1'b0;
      r_next.ien_set = 1'b0;
      if (i_cyc_en) begin
         r_next.flush = 1'b0;
         case (r_reg.st)
            RIU_EXEC: begin
               // the instruction in a flush cycle is still decoded but ignored, not executed
               if (kind != RIU_NONE) begin
                  r_next.st       = RIU_FLUSH;            // [RQ3] [RQ6] [RQ8]
                  r_next.pop      = 1'b1;                 // [RQ1] [RQ5] [RQ7]
                  r_next.pc_load  = 1'b1;                 // [RQ1] [RQ5] [RQ7]
                  r_next.pc_value = i_top_of_stack;       // [RQ1] [RQ5] [RQ7]
                  r_next.flush    = 1'b1;                 // [RQ9]
                  r_next.ien_set  = (kind == RIU_RETI);   // [RQ2] [RQ9]
                  if (kind == RIU_RETLIT) begin
                     r_next.w_load  = 1'b1;               // [RQ4]
                     r_next.w_value = i_instr[RIU_LIT_LSB +: RIU_DW]; // [RQ4]
                  end
               end
            end
            RIU_FLUSH: begin
               r_next.st = RIU_EXEC;                      // [RQ9]
            end
            default: begin
               r_next.st = RIU_EXEC;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         r_reg <= '{st: RIU_EXEC, pc_value: '0, w_value: '0, default: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_pop      = r_reg.pop;
   assign o_pc_load  = r_reg.pc_load;
   assign o_pc_value = r_reg.pc_value;
   assign o_w_load   = r_reg.w_load;
   assign o_w_value  = r_reg.w_value;
   assign o_global_interrupt_enable_set = r_reg.ien_set;
   assign o_global_interrupt_enable_bit = 3'(RIU_IEN_BIT); // [RQ2]
   assign o_flush    = r_reg.flush;
   assign o_busy     = (r_reg.st == RIU_FLUSH);
   assign o_flags_we = 1'b0;                              // [RQ3] [RQ6] [RQ8]

   sequence s_ret_start;
      i_cyc_en && r_reg.st == RIU_EXEC && kind != RIU_NONE;
   endsequence

   property p_pop_loads_pc;
      @(posedge i_clk) disable iff (i_rst)
      s_ret_start |=> o_pop && o_pc_load && o_pc_value == $past(i_top_of_stack);
   endproperty
   a_pop_loads_pc: assert property (p_pop_loads_pc) // [RQ1]
      else $error("return did not pop stack into pc");

   property p_reti_ien;
      @(posedge i_clk) disable iff (i_rst)
      (s_ret_start and kind == RIU_RETI) |=> o_global_interrupt_enable_set;
   endproperty
   a_reti_ien: assert property (p_reti_ien) // [RQ2]
      else $error("interrupt return did not set enable");

   property p_two_cycles;
      @(posedge i_clk) disable iff (i_rst)
      s_ret_start |=> o_busy && o_flush;
   endproperty
   a_two_cycles: assert property (p_two_cycles) // [RQ3]
      else $error("return did not enter flush cycle");

   property p_lit_w;
      @(posedge i_clk) disable iff (i_rst)
      (s_ret_start and kind == RIU_RETLIT) |=>
         o_w_load && o_w_value == $past(i_instr[RIU_LIT_LSB +: RIU_DW]);
   endproperty
   a_lit_w: assert property (p_lit_w) // [RQ4]
      else $error("literal not loaded into working register");

   property p_lit_pop;
      @(posedge i_clk) disable iff (i_rst)
      (s_ret_start and kind == RIU_RETLIT) |=> o_pop && o_pc_load;
   endproperty
   a_lit_pop: assert property (p_lit_pop) // [RQ5]
      else $error("literal return did not pop");

   property p_no_flags;
      @(posedge i_clk) disable iff (i_rst)
      !o_flags_we;
   endproperty
   a_no_flags: assert property (p_no_flags) // [RQ6]
      else $error("return wrote status flags");

   property p_ret_pop;
      @(posedge i_clk) disable iff (i_rst)
      (s_ret_start and kind == RIU_RET) |=> o_pop && !o_w_load;
   endproperty
   a_ret_pop: assert property (p_ret_pop) // [RQ7]
      else $error("subroutine return did not pop");

   property p_flush_ends;
      @(posedge i_clk) disable iff (i_rst)
      (o_busy && i_cyc_en) |=> !o_busy && !o_pop;
   endproperty
   a_flush_ends: assert property (p_flush_ends) // [RQ8]
      else $error("return took more than two cycles");

   property p_plain_no_ien;
      @(posedge i_clk) disable iff (i_rst)
      (s_ret_start and kind != RIU_RETI) |=> !o_global_interrupt_enable_set;
   endproperty
   a_plain_no_ien: assert property (p_plain_no_ien) // [RQ9]
      else $error("plain return touched interrupt enable");

   // the prefetched word seen during a flush must leave no trace
   sequence s_flush_step;
      o_busy && i_cyc_en;
   endsequence

   property p_flush_no_pulse;
      @(posedge i_clk) disable iff (i_rst)
      s_flush_step |=> !o_pc_load && !o_w_load && !o_global_interrupt_enable_set;
   endproperty
   a_flush_no_pulse: assert property (p_flush_no_pulse) // [RQ9]
      else $error("flushed word was acted on");

   property p_stall_holds;
      @(posedge i_clk) disable iff (i_rst)
      (o_busy && !i_cyc_en) |=> o_busy && o_flush && !o_pop;
   endproperty
   a_stall_holds: assert property (p_stall_holds) // [RQ9]
      else $error("stalled flush cycle did not hold");

   property p_pulse_one;
      @(posedge i_clk) disable iff (i_rst)
      o_pop |=> !o_pop && !o_pc_load;
   endproperty
   a_pulse_one: assert property (p_pulse_one) // [RQ8]
      else $error("pop pulse lasted more than one clock");

   property p_idle_quiet;
      @(posedge i_clk) disable iff (i_rst)
      (i_cyc_en && !o_busy && kind == RIU_NONE) |=> !o_pop && !o_busy;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) // [RQ7]
      else $error("non-return word started a return");

   property p_gated_start;
      @(posedge i_clk) disable iff (i_rst)
      (!i_cyc_en && !o_busy) |=> !o_pop && !o_busy;
   endproperty
   a_gated_start: assert property (p_gated_start) // [RQ1]
      else $error("return started without cycle enable");

   property p_pc_holds;
      @(posedge i_clk) disable iff (i_rst)
      o_busy |=> $stable(o_pc_value);
   endproperty
   a_pc_holds: assert property (p_pc_holds) // [RQ5]
      else $error("pc value changed in flush cycle");

   property p_w_holds;
      @(posedge i_clk) disable iff (i_rst)
      (s_ret_start and kind != RIU_RETLIT) |=> !o_w_load && $stable(o_w_value);
   endproperty
   a_w_holds: assert property (p_w_holds) // [RQ4]
      else $error("non-literal return touched working register");
endmodule : riu_return_unit

/* test_return_instruction_unit.sv */
// self-checking testbench for the return instruction unit
`timescale 1ns/10ps
module test_return_instruction_unit;
   import riu_pkg::*;
   logic               i_clk = 1'b0;
   logic               i_rst = 1'b1;
   logic               i_cyc_en = 1'b1;
   logic [RIU_IW-1:0]  i_instr = 14'h0000;
   logic [RIU_PCW-1:0] i_top_of_stack = 13'h0000;
   logic               o_pop, o_pc_load, o_w_load, ien_set, o_flush, o_busy, o_flags_we;
   logic [RIU_PCW-1:0] o_pc_value;
   logic [RIU_DW-1:0]  o_w_value;
   logic [2:0]         ien_bit;
   int                 n_errors = 0;
   int                 checks = 0;
   int                 cycles = 0;

   riu_return_unit dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cyc_en(i_cyc_en), .i_instr(i_instr),
      .i_top_of_stack(i_top_of_stack), .o_pop(o_pop), .o_pc_load(o_pc_load),
      .o_pc_value(o_pc_value), .o_w_load(o_w_load), .o_w_value(o_w_value),
      .o_global_interrupt_enable_set(ien_set), .o_global_interrupt_enable_bit(ien_bit),
      .o_flush(o_flush), .o_busy(o_busy),
      .o_flags_we(o_flags_we));

   initial begin
      forever #2.5 i_clk = ~i_clk;
   end

   // whole run needs well under 100 cycles; 2000 means a hang
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic step();
      @(posedge i_clk);
      #1;
   endtask : step

   // one return, then a prefetched return word that must be dropped
   task automatic exec(input logic [13:0] op, input logic [12:0] addr, input logic lit,
                       input logic ien);
      i_instr = op;
      i_top_of_stack = addr;
      step();
      chk(16'({o_pop, o_pc_load, o_w_load, ien_set, o_flush, o_busy, o_flags_we}),
          16'({4'hC | {2'h0, lit, ien}, 3'h6}));
      chk(16'(o_pc_value), 16'(addr));
      if (lit) chk(16'(o_w_value), 16'(op[7:0]));
      chk(16'(ien_bit), 16'h0007);
      i_instr = RIU_OP_RET;
      i_top_of_stack = ~addr;
      step();
      chk(16'({o_pop, o_pc_load, o_w_load, ien_set, o_flush, o_busy}), 16'h0000);
      chk(16'(o_pc_value), 16'(addr));
   endtask : exec

   // back to back: every kind, literal edges, both don't-care bits
   task automatic t_returns();
      exec(RIU_OP_RETI, 13'h1ABC, 1'b0, 1'b1);
      exec(14'h3400, 13'h0000, 1'b1, 1'b0);
      exec(14'h37FF, 13'h1FFF, 1'b1, 1'b0);
      exec(14'h35A5, 13'h0A5A, 1'b1, 1'b0);
      exec(14'h365A, 13'h15A5, 1'b1, 1'b0);
      exec(RIU_OP_RET, 13'h0555, 1'b0, 1'b0);
   endtask : t_returns

   // neighbouring opcodes are not returns
   task automatic t_other();
      logic [13:0] ops [5] = '{14'h0062, 14'h3C00, 14'h000A, 14'h3800, 14'h0001};
      foreach (ops[k]) begin
         i_instr = ops[k];
         step();
         chk(16'({o_pop, o_pc_load, o_w_load, ien_set, o_busy}), 16'h0000);
      end
   endtask : t_other

   // a stalled flush cycle keeps busy and ignores what is presented
   task automatic t_stall();
      exec(RIU_OP_RET, 13'h0ABC, 1'b0, 1'b0);
      i_instr = RIU_OP_RET;
      step();
      chk(16'(o_pc_value), 16'h1543);
      i_cyc_en = 1'b0;
      i_instr = RIU_OP_RETI;
      repeat (2) begin
         step();
         chk(16'({o_pop, ien_set, o_flush, o_busy}), 16'h0003);
      end
      i_cyc_en = 1'b1;
      step();
      chk(16'({o_pop, ien_set, o_busy}), 16'h0000);
      // a return offered while the cycle enable is low waits for it
      i_cyc_en = 1'b0;
      step();
      chk(16'({o_pop, o_pc_load, ien_set, o_busy}), 16'h0000);
      i_cyc_en = 1'b1;
      step();
      chk(16'({o_pop, ien_set, o_busy}), 16'h0007);
      i_instr = 14'h0000;
   endtask : t_stall

   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   initial begin
      repeat (6) @(posedge i_clk);
      #1;
      chk(16'({o_pop, o_pc_load, o_w_load, ien_set, o_flags_we}), 16'h0000);
      i_rst = 1'b0;
      step();
      t_returns();
      t_other();
      t_stall();
      test_done();
   end
endmodule : test_return_instruction_unit
